// ==== frs_defines.vh ====
/*
 * Shared constants of the frequency and rate-of-change stage logic:
 * register offsets, field positions, reset values, timing and codes.
 * Assumes inclusion by bare name from each design file.
 */
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH

// Register byte offsets
`define FRS_RATED_OFS 8'h00
`define FRS_AVG_OFS 8'h04
`define FRS_STG_THR_OFS 8'h10
`define FRS_STG_CFG_OFS 8'h14
`define FRS_STG_STRIDE 8'h08
`define FRS_STG1_THR_OFS 8'h18
`define FRS_STG1_CFG_OFS 8'h1C
`define FRS_STG2_THR_OFS 8'h20
`define FRS_STG2_CFG_OFS 8'h24
`define FRS_STG3_THR_OFS 8'h28
`define FRS_STG3_CFG_OFS 8'h2C
`define FRS_REC_DEV_OFS 8'h30
`define FRS_REC_CFG_OFS 8'h34
`define FRS_STATUS_OFS 8'h38
`define FRS_FSUM_OFS 8'h3C

// Stage configuration word fields
`define FRS_CFG_TIME_LSB 0
`define FRS_CFG_TIME_MSB 15
`define FRS_CFG_FEN_BIT 16
`define FRS_CFG_REN_BIT 17
`define FRS_CFG_BLK_LSB 18
`define FRS_CFG_BLK_MSB 22
`define FRS_CFG_UV_BIT 23
`define FRS_THR_RATE_LSB 16

// Recovery configuration word fields
`define FRS_REC_SEL_LSB 16
`define FRS_REC_SEL_MSB 19

// Reset values
`define FRS_RATED_RST 16'h1388
`define FRS_AVG_RST 5'h03
`define FRS_AVG_MIN 5'h03
`define FRS_AVG_MAX 5'h14
`define FRS_REC_OUT_RST 1'b1

// Timing
// One millisecond of 5 ns clock periods
`define FRS_MS_CYCLES 18'h30D40
`define FRS_MIN_RATE_MS 16'h0096
`define FRS_MIN_FREQ_MS 16'h0064

// Display codes
`define FRS_CODE_NONE 4'h0
`define FRS_CODE_REC_DUE 4'h9
`define FRS_CODE_REC_OVER 4'hA

`endif

// ==== frs_avg.v ====
/*
 * Frequency averaging: keeps the last twenty per-cycle frequency
 * samples, forms the sum over the selected window and the change
 * between successive three-cycle sums. Assumes samples arrive as
 * one-cycle strobes from logic on the same clock.
 */
`timescale 1ns/10ps
`include "frs_defines.vh"

module frs_avg (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Samples
    input wire smp_valid,
    input wire [15:0] smp,
    input wire [4:0] avg_n,
    // Results
    output reg [20:0] fsum_q,
    output reg signed [18:0] dsum_q,
    output reg fvalid_q,
    output reg rvalid_q
);

reg [15:0] hist_q [0:19];
reg [4:0] fill_q;
reg upd_q;
reg [17:0] sum3_prev_q;
reg [20:0] sum_n;
reg [17:0] sum3;
integer k;
integer m;

always @* begin
    sum_n = 21'h000000;
    for (k = 0; k < 20; k = k + 1) begin
        if (k < avg_n) begin
            sum_n = sum_n + {5'h00, hist_q[k]};
        end
    end
    sum3 = {2'h0, hist_q[0]} + {2'h0, hist_q[1]} + {2'h0, hist_q[2]};
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (m = 0; m < 20; m = m + 1) begin
            hist_q[m] <= 16'h0000;
        end
        fill_q <= 5'h00;
        upd_q <= 1'b0;
        sum3_prev_q <= 18'h00000;
        fsum_q <= 21'h000000;
        dsum_q <= 19'sh00000;
        fvalid_q <= 1'b0;
        rvalid_q <= 1'b0;
    end else begin
        upd_q <= smp_valid;
        if (smp_valid) begin
            // Moving window, newest first
            hist_q[0] <= smp;
            for (m = 1; m < 20; m = m + 1) begin
                hist_q[m] <= hist_q[m-1];
            end
            if (fill_q != 5'h14) begin
                fill_q <= fill_q + 5'h01;
            end
        end
        if (upd_q) begin
            fsum_q <= sum_n;
            fvalid_q <= (fill_q >= avg_n);
            // Successive three-cycle sums, independent of window length
            dsum_q <= $signed({1'b0, sum3}) - $signed({1'b0, sum3_prev_q});
            sum3_prev_q <= sum3;
            rvalid_q <= (fill_q >= 5'h04);
        end
    end
end

endmodule

// ==== frs_top.v ====
/*
 * Four frequency / rate-of-change protection stages and the shared
 * recovery stage, set up over an APB slave. Assumes a frequency
 * front end on pclk supplying one sample per signal cycle, and
 * asynchronous blocking and recovery-inhibit pins.
 */
`timescale 1ns/10ps
`include "frs_defines.vh"

module frs_top #(
    parameter [17:0] MS_CYCLES = `FRS_MS_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Frequency front end
    input wire smp_valid,
    input wire [15:0] smp_freq,
    input wire uv_block,
    // Asynchronous control pins
    input wire [4:0] ext_block,
    input wire rec_inhibit,
    // Stage and recovery outputs
    output reg [3:0] stage_start_q,
    output reg [3:0] stage_trip_q,
    output reg rec_out_q,
    output reg rec_run_q,
    output reg [3:0] disp_code_q
);

reg [15:0] rated_q;
reg [4:0] avg_n_q;
reg [31:0] thr_q [0:3];
reg [23:0] cfg_q [0:3];
reg [15:0] rec_dev_q;
reg [19:0] rec_cfg_q;
reg [15:0] op_cnt_q [0:3];
reg [3:0] tripped_q;
reg [15:0] rec_cnt_q;
reg [17:0] pre_q;
reg ms_tick_q;
reg [4:0] blk_s1_q;
reg [4:0] blk_s2_q;
reg inh_s1_q;
reg inh_s2_q;
wire [20:0] fsum;
wire signed [18:0] dsum;
wire fvalid;
wire rvalid;
reg [3:0] start_c;
reg [3:0] blocked_c;
reg [15:0] eff_time [0:3];
reg [31:0] rd_c;
reg rd_err_c;
reg [3:0] code_c;
reg in_band_c;
reg [21:0] band_lo;
reg [21:0] band_hi;
reg over;
reg fc;
reg rc;
reg [18:0] mag;
integer i;
integer j;
integer r;
integer t;

function [20:0] scale;
    input [15:0] val;
    input [4:0] n;
    begin
        scale = val * n;
    end
endfunction

function [15:0] max16;
    input [15:0] a;
    input [15:0] b;
    begin
        max16 = (a > b) ? a : b;
    end
endfunction

frs_avg i_frs_avg (
    .pclk(pclk),
    .presetn(presetn),
    .smp_valid(smp_valid),
    .smp(smp_freq),
    .avg_n(avg_n_q),
    .fsum_q(fsum),
    .dsum_q(dsum),
    .fvalid_q(fvalid),
    .rvalid_q(rvalid)
);

// Stage conditions
always @* begin
    mag = dsum[18] ? (19'h00000 - dsum) : dsum;
    for (i = 0; i < 4; i = i + 1) begin
        over = (thr_q[i][15:0] > rated_q);
        if (over) begin
            fc = fvalid && (fsum > scale(thr_q[i][15:0], avg_n_q));
        end else begin
            fc = fvalid && (fsum < scale(thr_q[i][15:0], avg_n_q));
        end
        // Sign follows stage direction, with or without frequency test
        rc = rvalid && (over ? !dsum[18] : dsum[18])
            && ({2'h0, mag} > {1'b0, scale(thr_q[i][31:16], `FRS_AVG_MIN)});
        start_c[i] = (cfg_q[i][`FRS_CFG_FEN_BIT] || cfg_q[i][`FRS_CFG_REN_BIT])
            && (!cfg_q[i][`FRS_CFG_FEN_BIT] || fc)
            && (!cfg_q[i][`FRS_CFG_REN_BIT] || rc);
        blocked_c[i] = |(cfg_q[i][`FRS_CFG_BLK_MSB:`FRS_CFG_BLK_LSB] & blk_s2_q)
            || (cfg_q[i][`FRS_CFG_UV_BIT] && uv_block);
        if (cfg_q[i][`FRS_CFG_REN_BIT]) begin
            eff_time[i] = max16(cfg_q[i][15:0], `FRS_MIN_RATE_MS);
        end else begin
            eff_time[i] = max16(cfg_q[i][15:0], `FRS_MIN_FREQ_MS);
        end
    end
end

// Recovery band around rated frequency
always @* begin
    band_lo = {1'b0, scale(rated_q, avg_n_q)} - {1'b0, scale(rec_dev_q, avg_n_q)};
    band_hi = {1'b0, scale(rated_q, avg_n_q)} + {1'b0, scale(rec_dev_q, avg_n_q)};
    in_band_c = fvalid && !band_lo[21] && ({1'b0, fsum} >= band_lo)
        && ({1'b0, fsum} <= band_hi);
end

// Display code: trips, then starts, then recovery
always @* begin
    code_c = `FRS_CODE_NONE;
    if (rec_run_q) begin
        code_c = `FRS_CODE_REC_DUE;
    end
    if (rec_out_q && rec_cfg_q[`FRS_REC_SEL_MSB:`FRS_REC_SEL_LSB] != 4'h0) begin
        code_c = `FRS_CODE_REC_OVER;
    end
    for (j = 3; j >= 0; j = j - 1) begin
        if (start_c[j]) begin
            code_c = j[3:0] + j[3:0] + 4'h1;
        end
    end
    for (j = 3; j >= 0; j = j - 1) begin
        if (tripped_q[j] && !blocked_c[j]) begin
            code_c = j[3:0] + j[3:0] + 4'h2;
        end
    end
end

// Register read decode
always @* begin
    rd_c = 32'h00000000;
    rd_err_c = 1'b0;
    case (paddr)
        `FRS_RATED_OFS: rd_c = {16'h0000, rated_q};
        `FRS_AVG_OFS: rd_c = {27'h0000000, avg_n_q};
        `FRS_STG_THR_OFS: rd_c = thr_q[0];
        `FRS_STG_CFG_OFS: rd_c = {8'h00, cfg_q[0]};
        `FRS_STG1_THR_OFS: rd_c = thr_q[1];
        `FRS_STG1_CFG_OFS: rd_c = {8'h00, cfg_q[1]};
        `FRS_STG2_THR_OFS: rd_c = thr_q[2];
        `FRS_STG2_CFG_OFS: rd_c = {8'h00, cfg_q[2]};
        `FRS_STG3_THR_OFS: rd_c = thr_q[3];
        `FRS_STG3_CFG_OFS: rd_c = {8'h00, cfg_q[3]};
        `FRS_REC_DEV_OFS: rd_c = {16'h0000, rec_dev_q};
        `FRS_REC_CFG_OFS: rd_c = {12'h000, rec_cfg_q};
        `FRS_STATUS_OFS: rd_c = {18'h00000, disp_code_q, rec_run_q, rec_out_q,
            stage_trip_q, stage_start_q};
        `FRS_FSUM_OFS: rd_c = {11'h000, fsum};
        default: rd_err_c = 1'b1;
    endcase
end

// APB slave: one wait state, answer on second access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        rated_q <= `FRS_RATED_RST;
        avg_n_q <= `FRS_AVG_RST;
        for (r = 0; r < 4; r = r + 1) begin
            thr_q[r] <= 32'h00000000;
            cfg_q[r] <= 24'h000000;
        end
        rec_dev_q <= 16'h0000;
        rec_cfg_q <= 20'h00000;
    end else begin
        pready <= psel && penable && !pready;
        pslverr <= psel && penable && !pready && rd_err_c;
        prdata <= (psel && penable && !pready && !pwrite) ? rd_c : 32'h00000000;
        if (psel && penable && pready && pwrite && !pslverr) begin
            case (paddr)
                `FRS_RATED_OFS: rated_q <= pwdata[15:0];
                `FRS_AVG_OFS: begin
                    if (pwdata[4:0] < `FRS_AVG_MIN) begin
                        avg_n_q <= `FRS_AVG_MIN;
                    end else if (pwdata[4:0] > `FRS_AVG_MAX) begin
                        avg_n_q <= `FRS_AVG_MAX;
                    end else begin
                        avg_n_q <= pwdata[4:0];
                    end
                end
                `FRS_STG_THR_OFS: thr_q[0] <= pwdata;
                `FRS_STG_CFG_OFS: cfg_q[0] <= pwdata[23:0];
                `FRS_STG1_THR_OFS: thr_q[1] <= pwdata;
                `FRS_STG1_CFG_OFS: cfg_q[1] <= pwdata[23:0];
                `FRS_STG2_THR_OFS: thr_q[2] <= pwdata;
                `FRS_STG2_CFG_OFS: cfg_q[2] <= pwdata[23:0];
                `FRS_STG3_THR_OFS: thr_q[3] <= pwdata;
                `FRS_STG3_CFG_OFS: cfg_q[3] <= pwdata[23:0];
                `FRS_REC_DEV_OFS: rec_dev_q <= pwdata[15:0];
                `FRS_REC_CFG_OFS: rec_cfg_q <= pwdata[19:0];
                default: rated_q <= rated_q;
            endcase
        end
    end
end

// Pin synchronisers and millisecond tick
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        blk_s1_q <= 5'h00;
        blk_s2_q <= 5'h00;
        inh_s1_q <= 1'b0;
        inh_s2_q <= 1'b0;
        pre_q <= 18'h00000;
        ms_tick_q <= 1'b0;
    end else begin
        blk_s1_q <= ext_block;
        blk_s2_q <= blk_s1_q;
        inh_s1_q <= rec_inhibit;
        inh_s2_q <= inh_s1_q;
        ms_tick_q <= (pre_q == MS_CYCLES - 18'h00001);
        if (pre_q == MS_CYCLES - 18'h00001) begin
            pre_q <= 18'h00000;
        end else begin
            pre_q <= pre_q + 18'h00001;
        end
    end
end

// Stage operate timers, same sequence for both directions
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (t = 0; t < 4; t = t + 1) begin
            op_cnt_q[t] <= 16'h0000;
        end
        tripped_q <= 4'h0;
        stage_start_q <= 4'h0;
        stage_trip_q <= 4'h0;
        disp_code_q <= `FRS_CODE_NONE;
    end else begin
        stage_start_q <= start_c;
        disp_code_q <= code_c;
        for (t = 0; t < 4; t = t + 1) begin
            if (!start_c[t]) begin
                op_cnt_q[t] <= 16'h0000;
                tripped_q[t] <= 1'b0;
            end else if (op_cnt_q[t] >= eff_time[t]) begin
                tripped_q[t] <= 1'b1;
            end else if (ms_tick_q) begin
                op_cnt_q[t] <= op_cnt_q[t] + 16'h0001;
            end
            stage_trip_q[t] <= tripped_q[t] && start_c[t] && !blocked_c[t];
        end
    end
end

// Recovery stage
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rec_cnt_q <= 16'h0000;
        rec_out_q <= `FRS_REC_OUT_RST;
        rec_run_q <= 1'b0;
    end else begin
        rec_run_q <= 1'b0;
        if (|(stage_trip_q & rec_cfg_q[`FRS_REC_SEL_MSB:`FRS_REC_SEL_LSB])) begin
            rec_cnt_q <= 16'h0000;
            rec_out_q <= 1'b0;
        end else if (inh_s2_q || !in_band_c) begin
            rec_cnt_q <= 16'h0000;
        end else if (!rec_out_q) begin
            rec_run_q <= 1'b1;
            if (rec_cnt_q >= rec_cfg_q[15:0]) begin
                rec_out_q <= 1'b1;
                rec_run_q <= 1'b0;
            end else if (ms_tick_q) begin
                rec_cnt_q <= rec_cnt_q + 16'h0001;
            end
        end
    end
end

endmodule

// ==== frs_fe_model.sv ====
/* Frequency front end model: one sample strobe every four clocks.
   Assumes the bench sets the target frequency and the step per sample. */
`timescale 1ns/10ps
module frs_fe_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic [15:0] target,
    input wire logic [15:0] step,
    // Samples
    output logic smp_valid,
    output logic [15:0] smp_freq
);
    logic [15:0] freq_q;
    logic [1:0] div_q;
    // Sample bus shows garbage outside its strobe
    assign smp_freq = smp_valid ? freq_q : ~freq_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            smp_valid <= 1'b0;
            freq_q <= 16'h1388;
        end else begin
            div_q <= div_q + 2'h1;
            smp_valid <= (div_q == 2'h3);
            if (div_q == 2'h3) begin
                if (freq_q + step < target)
                    freq_q <= freq_q + step;
                else if (freq_q > target + step)
                    freq_q <= freq_q - step;
                else
                    freq_q <= target;
            end
        end
    end
endmodule

// ==== frs_chk_properties.sv ====
/* Checker for the stage logic top: APB timing, trip and recovery.
   Assumes binding into the top, seeing only its ports. */
`timescale 1ns/10ps
module frs_chk #(
    parameter [17:0] MS_CYCLES = 18'h00004
) (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // APB
    input logic psel,
    input logic penable,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // Pins and outputs
    input logic rec_inhibit,
    input logic [3:0] stage_start_q,
    input logic [3:0] stage_trip_q,
    input logic rec_out_q,
    input logic rec_run_q
);
    logic [31:0] on_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles stage 0 has been started
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            on_q <= 32'h0;
        else
            on_q <= stage_start_q[0] ? on_q + 32'h1 : 32'h0;
    end
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_apb_one_wait: assert property (s_setup_access |=> pready)
        else $error("pready late");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_trip_needs_start: assert property ((stage_trip_q & ~stage_start_q) == 4'h0)
        else $error("trip without start");
    a_trip_min_delay: assert property ($rose(stage_trip_q[0]) |-> on_q >= 98 * MS_CYCLES)
        else $error("trip too early");
    a_rec_drop_cause: assert property ($fell(rec_out_q) |-> (stage_trip_q | $past(stage_trip_q)) != 4'h0)
        else $error("recovery drop without trip");
    a_inhibit_stops_timer: assert property (rec_inhibit [*4] |-> !rec_run_q)
        else $error("recovery runs while inhibited");
endmodule
bind frs_top frs_chk #(.MS_CYCLES(MS_CYCLES)) i_frs_chk (.*);

// ==== tb_frs_top.sv ====
/* Testbench of the stage logic: APB tasks and directed scenarios.
   Assumes the front end model and the checker bind are compiled. */
`timescale 1ns/10ps
module tb_frs_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic rec_inhibit = 1'b0;
    logic uv_block = 1'b0;
    logic [4:0] ext_block = 5'h00;
    logic [15:0] target = 16'h1388;
    logic [15:0] step = 16'h1000;
    logic [31:0] prdata;
    logic pready, pslverr, smp_valid, rec_out_q, rec_run_q;
    logic [15:0] smp_freq;
    logic [3:0] stage_start_q, stage_trip_q, disp_code_q;
    int err_count = 0;
    int cmp_count = 0;

    always #2.5 pclk = ~pclk;

    frs_fe_model i_frs_fe_model (.pclk(pclk), .presetn(presetn), .target(target),
        .step(step), .smp_valid(smp_valid), .smp_freq(smp_freq));
    frs_top #(.MS_CYCLES(18'h00004)) i_frs_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_valid(smp_valid),
        .smp_freq(smp_freq), .uv_block(uv_block), .ext_block(ext_block),
        .rec_inhibit(rec_inhibit), .stage_start_q(stage_start_q),
        .stage_trip_q(stage_trip_q), .rec_out_q(rec_out_q), .rec_run_q(rec_run_q),
        .disp_code_q(disp_code_q));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rdat, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check(pready, 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rdat;
        logic e;
        xfer(1'b1, a, d, rdat, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] d;
        logic e;
        xfer(1'b0, a, 32'h0, d, e);
        check(d, exp);
        check(e, experr);
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        end_of_test;
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h00001388, 1'b0);
        rd(8'h38, 32'h00000100, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        wr(8'h04, 32'h2);
        rd(8'h04, 32'h3, 1'b0);
        // Stage 0 above rated, frequency function only
        wr(8'h10, 32'h000013EC);
        wr(8'h14, 32'h00050000);
        target <= 16'h1450;
        wt(40);
        check(stage_start_q, 4'h1);
        check(disp_code_q, 4'h1);
        wt(300);
        check(stage_trip_q, 4'h0);
        wt(120);
        check({stage_trip_q, disp_code_q}, 8'h12);
        ext_block <= 5'h01;
        wt(10);
        check({stage_start_q, stage_trip_q}, 8'h10);
        ext_block <= 5'h00;
        wt(10);
        // Recovery on stage 0, band 50, time 10
        wr(8'h30, 32'h32);
        wr(8'h34, 32'h0001000A);
        wt(3);
        check(rec_out_q, 1'b0);
        target <= 16'h13B0;
        rec_inhibit <= 1'b1;
        wt(100);
        check({stage_start_q, stage_trip_q, rec_run_q, rec_out_q}, 10'h0);
        rec_inhibit <= 1'b0;
        wt(20);
        check({rec_run_q, disp_code_q}, 5'h19);
        // Inhibit aborts a timer already running
        rec_inhibit <= 1'b1;
        wt(10);
        check(rec_run_q, 1'b0);
        rec_inhibit <= 1'b0;
        wt(20);
        check(rec_run_q, 1'b1);
        wt(60);
        check({rec_out_q, disp_code_q}, 5'h1A);
        // Stage 1 below rated, rate function only
        wr(8'h18, 32'h00011324);
        wr(8'h1C, 32'h00020000);
        step <= 16'h0002;
        target <= 16'h15E0;
        wt(200);
        check(stage_start_q[1], 1'b0);
        target <= 16'h0FA0;
        wt(60);
        check(stage_start_q[1], 1'b1);
        wt(520);
        check(stage_trip_q[1], 1'b0);
        wt(100);
        check(stage_trip_q[1], 1'b1);
        check({stage_start_q[3:2], stage_trip_q[3:2]}, 4'h0);
        // Stage 2 above rated, both functions, undervoltage blocking
        uv_block <= 1'b1;
        wr(8'h20, 32'h000113EC);
        wr(8'h24, 32'h00830000);
        step <= 16'h0004;
        target <= 16'h1900;
        wt(40);
        check(stage_start_q[2], 1'b0);
        wt(460);
        check(stage_start_q[2], 1'b1);
        wt(700);
        check({stage_start_q[2], stage_trip_q[2]}, 2'b10);
        uv_block <= 1'b0;
        wt(3);
        check(stage_trip_q[2], 1'b1);
        // Falling frequency above threshold: rate sign wrong for stage 2
        target <= 16'h1450;
        wt(40);
        check({stage_start_q[2], stage_start_q[0]}, 2'b01);
        end_of_test;
    end
endmodule
